// *** pkg/ifrd_pkg.sv ***
// Constants for the routing word decoder: field positions, codes, register map.
// Assumes a 32-bit routing word and a 32-bit AXI4-Lite register bus.
package ifrd_pkg;

  // Routing word layout
  localparam int IFW          = 32;
  localparam int RCF_W        = 24;
  localparam int BIT_DIR      = 27;
  localparam int PS_HI        = 26;
  localparam int PS_LO        = 25;
  localparam int BIT_CAMP     = 24;
  localparam int EPA_W        = 12;

  // Path select codes
  localparam logic [1:0] PS_SRC_ROUTE = 2'h0;
  localparam logic [1:0] PS_DST_A     = 2'h1;
  localparam logic [1:0] PS_RESERVED  = 2'h2;
  localparam logic [1:0] PS_DST_B     = 2'h3;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_ADDRS    = 4'h8;
  localparam logic [3:0] OFS_COUNT    = 4'hC;

  // Control register fields and reset value
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_PORT_LO = 8;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_FF01;

  // Status register fields
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_PORT_LO  = 8;
  localparam int STAT_PS_LO    = 16;
  localparam int STAT_DIR_BIT  = 18;
  localparam int STAT_CAMP_BIT = 19;

  // Counter fields
  localparam int CNT_REJ_LO   = 0;
  localparam int CNT_CONN_LO  = 16;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CONN,
    ST_REJ
  } ifrd_state_t;

endpackage : ifrd_pkg

// *** rtl/ifrd_route_decoder.sv ***
// Routing word decoder and crossbar input-port controller with AXI4-Lite registers.
// Assumes the source holds src_request and src_ifield until connect or withdrawal,
// and that port_busy reflects output ports already in use, synchronous to aclk.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ifrd_route_decoder #(
  parameter int SUBW  = 4,
  parameter int DATAW = 32,
  parameter int CTLW  = 4
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [31:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [31:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         src_request,
  input  wire logic [ifrd_pkg::IFW-1:0]     src_ifield,
  input  wire logic [CTLW-1:0]              src_ctl,
  input  wire logic [DATAW-1:0]             src_data,
  output logic                              src_connect,
  output logic                              src_reject,
  input  wire logic [(1<<SUBW)-1:0]         port_busy,
  output logic                              dst_request,
  output logic [SUBW-1:0]                   dst_sel,
  output logic [ifrd_pkg::IFW-1:0]          dst_ifield,
  output logic [CTLW-1:0]                   dst_ctl,
  output logic [DATAW-1:0]                  dst_data
);
  import ifrd_pkg::*;

  // Output port picked from a routing word
  function automatic logic [SUBW-1:0] pick_port(input logic [IFW-1:0] w);
    logic [RCF_W-1:0] rcf;
    logic [EPA_W-1:0] dest;
    rcf  = w[RCF_W-1:0];
    dest = w[EPA_W-1:0];
    if (w[PS_HI:PS_LO] == PS_SRC_ROUTE)
    begin
      if (w[BIT_DIR])
        pick_port = rcf[RCF_W-1 -: SUBW];
      else
        pick_port = rcf[SUBW-1:0];
    end
    else
    begin
      // Endpoint address low bits select the port; no address table here
      if (w[BIT_DIR])
        dest = w[2*EPA_W-1:EPA_W];
      else
        dest = w[EPA_W-1:0];
      pick_port = dest[SUBW-1:0];
    end
  endfunction : pick_port

  // Routing word as passed on to the next stage
  function automatic logic [IFW-1:0] next_word(input logic [IFW-1:0] w,
                                                input logic [SUBW-1:0] own);
    logic [RCF_W-1:0] rcf;
    rcf       = w[RCF_W-1:0];
    next_word = w;
    if (w[PS_HI:PS_LO] == PS_SRC_ROUTE)
    begin
      if (w[BIT_DIR])
        rcf = {rcf[RCF_W-SUBW-1:0], own};
      else
        rcf = {own, rcf[RCF_W-1:SUBW]};
      next_word[RCF_W-1:0] = rcf;
    end
  endfunction : next_word

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    apply_strb = r;
  endfunction : apply_strb

  // Register bus state
  logic             aw_have_reg, aw_have_next;
  logic             w_have_reg, w_have_next;
  logic [3:0]       awaddr_reg, awaddr_next;
  logic [31:0]      wdata_reg, wdata_next;
  logic [3:0]       wstrb_reg, wstrb_next;
  logic             bvalid_reg, bvalid_next;
  logic [1:0]       bresp_reg, bresp_next;
  logic             rvalid_reg, rvalid_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [1:0]       rresp_reg, rresp_next;
  logic [31:0]      ctrl_reg, ctrl_next;

  // Connection state
  ifrd_state_t      state_reg, state_next;
  logic [IFW-1:0]   word_reg, word_next;
  logic [SUBW-1:0]  sel_reg, sel_next;
  logic [IFW-1:0]   out_word_reg, out_word_next;
  logic [CTLW-1:0]  ctl_reg, ctl_next;
  logic [DATAW-1:0] data_reg, data_next;
  logic [15:0]      rej_cnt_reg, rej_cnt_next;
  logic [15:0]      conn_cnt_reg, conn_cnt_next;

  logic             enable;
  logic [SUBW-1:0]  own_port;
  logic [SUBW-1:0]  cand_sel;
  logic [1:0]       cand_ps;
  logic [31:0]      status_word;
  logic [31:0]      addrs_word;

  assign enable   = ctrl_reg[CTRL_EN_BIT];
  assign own_port = ctrl_reg[CTRL_PORT_LO +: SUBW];
  assign cand_sel = pick_port(src_ifield);
  assign cand_ps  = src_ifield[PS_HI:PS_LO];

  assign status_word = {12'h000, word_reg[BIT_CAMP], word_reg[BIT_DIR],
                        word_reg[PS_HI:PS_LO], 8'(sel_reg), 6'h00, 2'(state_reg)};
  assign addrs_word  = {8'h00, word_reg[RCF_W-1:0]};

  // Connection sequencing
  always_comb
  begin
    state_next    = state_reg;
    word_next     = word_reg;
    sel_next      = sel_reg;
    out_word_next = out_word_reg;
    ctl_next      = '0;
    data_next     = '0;
    rej_cnt_next  = rej_cnt_reg;
    conn_cnt_next = conn_cnt_reg;
    case (state_reg)
      ST_IDLE:
      begin
        // Word is sampled with the request; later changes are not followed
        if (src_request && enable)
        begin
          word_next     = src_ifield;
          sel_next      = cand_sel;
          out_word_next = next_word(src_ifield, own_port);
          if (cand_ps == PS_RESERVED)
          begin
            state_next   = ST_REJ;
            rej_cnt_next = rej_cnt_reg + CNT_ONE;
          end
          else if (!port_busy[cand_sel])
          begin
            state_next    = ST_CONN;
            conn_cnt_next = conn_cnt_reg + CNT_ONE;
          end
          else if (src_ifield[BIT_CAMP])
            state_next = ST_WAIT;
          else
          begin
            state_next   = ST_REJ;
            rej_cnt_next = rej_cnt_reg + CNT_ONE;
          end
        end
      end
      ST_WAIT:
      begin
        // Retried every cycle; a camp-on wait ends on withdrawal or when the port frees
        if (!src_request)
          state_next = ST_IDLE;
        else if (!port_busy[sel_reg])
        begin
          state_next    = ST_CONN;
          conn_cnt_next = conn_cnt_reg + CNT_ONE;
        end
      end
      ST_CONN:
      begin
        if (!src_request)
          state_next = ST_IDLE;
        else
        begin
          ctl_next  = src_ctl;
          data_next = src_data;
        end
      end
      ST_REJ:
      begin
        if (!src_request)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= ST_IDLE;
      word_reg     <= '0;
      sel_reg      <= '0;
      out_word_reg <= '0;
      ctl_reg      <= '0;
      data_reg     <= '0;
      rej_cnt_reg  <= '0;
      conn_cnt_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      word_reg     <= word_next;
      sel_reg      <= sel_next;
      out_word_reg <= out_word_next;
      ctl_reg      <= ctl_next;
      data_reg     <= data_next;
      rej_cnt_reg  <= rej_cnt_next;
      conn_cnt_reg <= conn_cnt_next;
    end
  end

  assign src_connect = (state_reg == ST_CONN);
  assign src_reject  = (state_reg == ST_REJ);
  assign dst_request = (state_reg == ST_CONN);
  assign dst_sel     = sel_reg;
  assign dst_ifield  = out_word_reg;
  assign dst_ctl     = ctl_reg;
  assign dst_data    = data_reg;

  // AXI4-Lite slave: address and data taken in either order, one write at a time
  always_comb
  begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ctrl_next    = ctrl_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (awaddr_reg)
        OFS_CTRL:   ctrl_next = apply_strb(ctrl_reg, wdata_reg, wstrb_reg) & CTRL_MASK;
        OFS_STATUS: bresp_next = RESP_OKAY;
        OFS_ADDRS:  bresp_next = RESP_OKAY;
        OFS_COUNT:  bresp_next = RESP_OKAY;
        default:    bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr[3:0])
        OFS_CTRL:   rdata_next = ctrl_reg;
        OFS_STATUS: rdata_next = status_word;
        OFS_ADDRS:  rdata_next = addrs_word;
        OFS_COUNT:  rdata_next = {conn_cnt_reg, rej_cnt_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
      ctrl_reg    <= CTRL_RESET;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  // Address upper bits ignored: the map aliases every 16 bytes
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

endmodule : ifrd_route_decoder

// *** verif/ifrd_route_decoder_asserts.sv ***
// Checker on the link ports of the routing word decoder.
// Assumes enable stays set whenever a free port is asked for.
`timescale 1ns/1ps
module ifrd_route_decoder_chk #(
  parameter int SUBW  = 4,
  parameter int DATAW = 32,
  parameter int CTLW  = 4
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 src_request,
  input wire logic [31:0]          src_ifield,
  input wire logic [CTLW-1:0]      src_ctl,
  input wire logic [DATAW-1:0]     src_data,
  input wire logic                 src_connect,
  input wire logic                 src_reject,
  input wire logic [(1<<SUBW)-1:0] port_busy,
  input wire logic                 dst_request,
  input wire logic [SUBW-1:0]      dst_sel,
  input wire logic [31:0]          dst_ifield,
  input wire logic [CTLW-1:0]      dst_ctl,
  input wire logic [DATAW-1:0]     dst_data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0]      ps;
  logic [SUBW-1:0] lo, hi, da;
  assign ps = src_ifield[26:25];
  assign lo = src_ifield[SUBW-1:0];
  assign hi = src_ifield[23 -: SUBW];
  assign da = src_ifield[27] ? src_ifield[12 +: SUBW] : lo;
  property p_sr0;
    $rose(src_request) && ps == 2'h0 && !src_ifield[27] && !port_busy[lo] |=> src_connect
      && dst_sel == $past(lo) && dst_ifield[23-SUBW:0] == $past(src_ifield[23:SUBW]);
  endproperty
  a_sr0: assert property (p_sr0)
    else $error("right shift route wrong");
  property p_sr1;
    $rose(src_request) && ps == 2'h0 && src_ifield[27] && !port_busy[hi] |=> src_connect
      && dst_sel == $past(hi) && dst_ifield[23:SUBW] == $past(src_ifield[23-SUBW:0]);
  endproperty
  a_sr1: assert property (p_sr1)
    else $error("left shift route wrong");
  property p_da;
    $rose(src_request) && src_ifield[25] && !port_busy[da] |=> src_connect
      && dst_sel == $past(da) && dst_ifield == $past(src_ifield);
  endproperty
  a_da: assert property (p_da)
    else $error("address route wrong");
  property p_rsv;
    $rose(src_request) && ps == 2'h2 |=> src_reject && !src_connect;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved path routed");
  property p_camp;
    $rose(src_request) && src_ifield[24] && ps != 2'h2 |=> !src_reject;
  endproperty
  a_camp: assert property (p_camp)
    else $error("camp-on rejected");
  property p_fwd;
    src_connect && $past(src_connect) |-> dst_data == $past(src_data)
      && dst_ctl == $past(src_ctl);
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("path not transparent");
  property p_hold;
    src_connect && src_request |=> src_connect;
  endproperty
  a_hold: assert property (p_hold)
    else $error("path dropped early");
  property p_drop;
    !src_request && (src_connect || src_reject) |=> !src_connect && !src_reject && !dst_request;
  endproperty
  a_drop: assert property (p_drop)
    else $error("no release on withdrawal");
  property p_dreq;
    dst_request == src_connect;
  endproperty
  a_dreq: assert property (p_dreq)
    else $error("output request mismatch");
endmodule : ifrd_route_decoder_chk
bind ifrd_route_decoder ifrd_route_decoder_chk #(.SUBW(SUBW), .DATAW(DATAW), .CTLW(CTLW)) u_chk (
  .aclk, .aresetn, .src_request, .src_ifield, .src_ctl, .src_data, .src_connect, .src_reject,
  .port_busy, .dst_request, .dst_sel, .dst_ifield, .dst_ctl, .dst_data);

// *** verif/ifrd_src_model.sv ***
// Source side model: raises a connection request carrying a routing word.
// Assumes the bench drives go and word just after rising clock edges.
`timescale 1ns/1ps
module ifrd_src_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic [31:0] word,
  output logic             src_request,
  output logic [31:0]      src_ifield
);
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      src_request <= 1'b0;
      src_ifield  <= 32'h0;
    end
    else if (!src_request && go)
    begin
      src_request <= 1'b1;
      src_ifield  <= word;
    end
    else if (src_request && !go)
    begin
      src_request <= 1'b0;  // Held until here
      src_ifield  <= ~src_ifield;
    end
endmodule : ifrd_src_model

// *** verif/test_ifrd_route_decoder.sv ***
// Self-checking bench for the routing word decoder.
// Assumes a source model on the link and a register bus master here.
`timescale 1ns/1ps
module test_ifrd_route_decoder;
  import ifrd_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, req, cnx, rej, dreq;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, word = '0, sdat = '0, lastw = '0;
  logic [31:0] rdata, ifl, dif, ddat;
  logic [3:0]  wstrb = '0, sctl = '0, own = '0, dsel, dctl;
  logic [1:0]  bresp, rresp;
  logic [15:0] busy = '0, cn = '0, rj = '0;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (++cyc == 6000) begin bad_count++; stop_test(); end
  ifrd_route_decoder dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_request(req), .src_ifield(ifl), .src_ctl(sctl), .src_data(sdat), .src_connect(cnx),
    .src_reject(rej), .port_busy(busy), .dst_request(dreq), .dst_sel(dsel),
    .dst_ifield(dif), .dst_ctl(dctl), .dst_data(ddat));
  ifrd_src_model src (.aclk, .aresetn, .go, .word, .src_request(req), .src_ifield(ifl));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Ready is sampled mid-cycle; it only moves after rising edges
  task automatic axi(input bit w, input logic [31:0] a, d, ed, input logic [3:0] s,
                     input logic [1:0] er);
    logic ta, tw, tr, tk;
    logic [1:0] r;
    logic [31:0] q;
    @(posedge aclk);
    if (w) begin awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1; end
    else begin araddr <= a; arvalid <= 1'b1; rready <= 1'b1; end
    tk = 1'b0;
    while (!tk)
    begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tr = arvalid && arready;
      tk = w ? bvalid : rvalid; r = w ? bresp : rresp; q = rdata;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tk) begin bready <= 1'b0; rready <= 1'b0; end
    end
    chk("resp", r, er);
    if (!w) chk("rdata", q, ed);
  endtask : axi
  function automatic logic [3:0] esel(input logic [31:0] w);
    if (w[25]) return w[27] ? w[15:12] : w[3:0];
    return w[27] ? w[23:20] : w[3:0];
  endfunction : esel
  function automatic logic [23:0] efld(input logic [31:0] w);
    if (w[25]) return w[23:0];
    return w[27] ? {w[19:0], own} : {own, w[23:4]};
  endfunction : efld
  task automatic link(input logic [31:0] w, input logic [15:0] bz, input bit wd);
    logic [3:0] s;
    logic c, r;
    logic [31:0] d;
    s = esel(w);
    c = w[26:25] != 2'h2 && !bz[s];
    r = w[26:25] == 2'h2 || (bz[s] && !w[24]);
    lastw = w;
    @(posedge aclk);
    busy <= bz; word <= w; go <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("connect", cnx, c);
    chk("reject", rej, r);
    if (!c && !r)
    begin
      @(posedge aclk);
      if (wd) go <= 1'b0; else busy <= '0;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      c = !wd;
      chk("camp", cnx, c);
    end
    if (c)
    begin
      cn++;
      chk("sel", dsel, s);
      chk("ifield", dif, {w[31:24], efld(w)});
      d = $urandom;
      @(posedge aclk);
      sdat <= d; sctl <= d[3:0];
      repeat (1) @(posedge aclk);
      @(negedge aclk);
      chk("data", ddat, d);
      chk("ctl", dctl, d[3:0]);
    end
    if (r) rj++;
    @(posedge aclk);
    go <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("idle", {cnx, rej, dreq}, 3'h0);
  endtask : link
  initial
  begin
    logic [31:0] w, b;
    void'($urandom(86878));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, OFS_CTRL, 0, CTRL_RESET, 4'h0, RESP_OKAY);
    axi(1, OFS_CTRL, 32'hFFFF_FF00, 0, 4'h2, RESP_OKAY);
    axi(0, OFS_CTRL, 0, 32'h0000_FF01, 4'h0, RESP_OKAY);
    axi(1, OFS_CTRL, 32'h0000_0501, 0, 4'hF, RESP_OKAY);
    own = 4'h5;
    axi(0, 32'h3, 0, 0, 4'h0, RESP_SLVERR);
    link(32'h0000_000F, 16'h0000, 0);
    link(32'h08F0_0000, 16'h7FFF, 0);
    link(32'h0A00_50C3, 16'h0000, 0);
    link(32'h0C00_0000, 16'hFFFF, 0);
    link(32'h0100_0003, 16'h0008, 1);
    link(32'h0100_0003, 16'h0008, 0);
    link(32'h0000_0003, 16'h0008, 0);
    axi(0, OFS_STATUS, 0, 32'h0000_0300, 4'h0, RESP_OKAY);
    // Enable off: a camp-on request must be ignored, not parked in the wait state
    axi(1, OFS_CTRL, 32'h0000_0500, 0, 4'hF, RESP_OKAY);
    @(posedge aclk);
    busy <= 16'h0008; word <= 32'h0100_0003; go <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("off", {cnx, rej, dreq}, 3'h0);
    axi(0, OFS_STATUS, 0, 32'h0000_0300, 4'h0, RESP_OKAY);
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    axi(1, OFS_CTRL, 32'h0000_0501, 0, 4'hF, RESP_OKAY);
    repeat (40)
    begin
      w = $urandom;
      b = $urandom;
      link(w, b[15:0] & b[31:16], w[31]);
    end
    axi(1, OFS_ADDRS, 32'h0, 0, 4'hF, RESP_OKAY);
    axi(0, OFS_ADDRS, 0, {8'h00, lastw[23:0]}, 4'h0, RESP_OKAY);
    axi(0, OFS_COUNT, 0, {cn, rj}, 4'h0, RESP_OKAY);
    stop_test();
  end
endmodule : test_ifrd_route_decoder
